// ### core/adcs_buf.sv
// two-entry valid/ready buffer between the converter core and the shifter
// assumes both sides on the same clock
module adcs_buf #(
	parameter int unsigned W = 18
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	logic [W-1:0] mem_r [2];
	logic         wr_ptr_r;
	logic         rd_ptr_r;
	logic [1:0]   count_r;
	logic [1:0]   count_nxt;
	logic         push;
	logic         pop;

	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_valid = (count_r != 2'h0);
	assign out_data  = mem_r[rd_ptr_r];

	always_comb begin
		count_nxt = count_r;
		if (push && !pop)
			count_nxt = count_r + 2'h1;
		else if (pop && !push)
			count_nxt = count_r - 2'h1;
	end

	always_ff @(posedge clk) begin
		if (push)
			mem_r[wr_ptr_r] <= in_data;
	end

	// ready is registered so the source sees it straight from a flop
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
			count_r  <= 2'h0;
			in_ready <= 1'b1;
		end else begin
			if (push)
				wr_ptr_r <= ~wr_ptr_r;
			if (pop)
				rd_ptr_r <= ~rd_ptr_r;
			count_r  <= count_nxt;
			in_ready <= (count_nxt != 2'h2);
		end
	end
endmodule

// ### core/adcs_pkg.sv
// constants shared by the serial configuration port of the converter
// assumes a 20 MHz core clock that oversamples the host's pins
package adcs_pkg;
	localparam int unsigned RESULT_W       = 18;
	localparam int unsigned STATUS_W       = 6;
	localparam int unsigned FRAME_W        = 24;
	localparam int unsigned BYTE_W         = 8;
	localparam logic [4:0]  RESULT_BITS    = 5'h12;
	localparam logic [4:0]  FRAME_BITS     = 5'h18;
	localparam logic [4:0]  READ_BITS      = 5'h09;
	localparam logic [3:0]  CMD_LAST       = 4'h7;
	localparam logic [3:0]  DATA_LAST      = 4'h7;
	localparam logic [1:0]  PWRUP_WAIT     = 2'h3;
	// the only register, at address 0x0
	localparam logic [1:0]  CFG_OFFSET     = 2'h0;
	localparam logic [7:0]  CFG_RESET      = 8'hE1;
	localparam int unsigned CFG_STATUS_EN  = 4;
	localparam int unsigned CFG_SPAN       = 3;
	localparam int unsigned CFG_KICKBACK   = 2;
	localparam int unsigned CFG_EARLY      = 1;
	localparam int unsigned CFG_CLAMP      = 0;
	localparam logic [7:0]  CMD_WRITE      = 8'h14;
	localparam logic [7:0]  CMD_READ       = 8'h54;
	localparam logic [1:0]  STATUS_RSVD    = 2'h0;
	typedef enum logic [1:0] {RX_HUNT, RX_CMD, RX_DATA} adcs_rx_t;
endpackage

// ### core/adcs_port.sv
// serial interface and configuration register of the 18-bit converter
// assumes pins asynchronous to CLK; SCK is oversampled, never used as a clock
// assumes the converter core hands results over a valid/ready stream

// Summary of operation
// - conversion-start rise samples serial input: high selects chip-select, low daisy-chain
// - four-wire: conversion-start launches, serial input low frames the readback
// - daisy-chain passes serial input on to serial output like a shift register
// - busy indicator puts a start bit before the result bits
// - chip-select: busy indicator on if either pin low when conversion ends
// - after power-up output low unless both pins high, then high impedance
// - early-readout bit set disables busy indicator in three- and four-wire
// - status-enable appends status bits right after last result bit
// - register access: 16-bit frame, command byte then data, conversion-start low
// - receiver skips ones until first zero, which is the first of eight command bits
// - command bit 7 write gate, bit 6 read/write, rest 010100
// - access only with conversion-start low; sample on SCK rise, drive on fall
// - conversion-start rise ends transfer: high impedance, or low in daisy-chain
// - register write takes effect even during a conversion
// - lowest written bit of configuration is reserved and ignored
// - configuration at 0x0, fields 4..0, resets to 0xE1
// - clamp flag read-only, active low, sticky, cleared by read once clear
// - six status bits: clamp, span, kickback, early readout, two reserved
// - output released after sixth status bit outside daisy-chain
// - three-wire: most significant bit appears when conversion-start falls
// - bits shift on SCK falls; release on the fall after the last result or status bit, or conversion-start rise
// - early readout: previous result loaded at conversion-start rise, readable once the conversion ends
module adcs_port (
	input  wire logic                          CLK,
	input  wire logic                          NRST,
	input  wire logic                          CONVERSION_START_PIN,
	input  wire logic                          SERIAL_INPUT_PIN,
	input  wire logic                          SCK,
	output logic                               SERIAL_OUTPUT_PIN_O,
	output logic                               SERIAL_OUTPUT_PIN_OE,
	input  wire logic [adcs_pkg::RESULT_W-1:0] RESULT_DATA,
	input  wire logic                          RESULT_VALID,
	output logic                               RESULT_READY,
	input  wire logic                          CLAMP_ACTIVE,
	output logic                               CONV_START,
	output logic                               SPAN_COMPRESS,
	output logic                               LOW_KICKBACK,
	output logic                               EARLY_READOUT
);
	logic [3:0]                        pins_s;
	logic                              cnv_s;
	logic                              sdi_s;
	logic                              sck_s;
	logic                              clamp_s;
	logic                              cnv_d_r;
	logic                              sck_d_r;
	logic                              sel_d_r;
	logic                              cnv_rise;
	logic                              sck_rise;
	logic                              sck_fall;
	logic                              sel;
	logic                              sel_fall;
	logic                              sel_rise;
	logic                              edges_on;
	logic                              daisy_r;
	logic                              conv_r;
	logic                              status_en_r;
	logic                              clamp_flag_r;
	logic                              clamp_conv_r;
	logic [adcs_pkg::RESULT_W-1:0]     last_r;
	logic                              buf_valid;
	logic [adcs_pkg::RESULT_W-1:0]     buf_data;
	logic                              res_take;
	logic [adcs_pkg::STATUS_W-1:0]     status;
	logic [adcs_pkg::STATUS_W-1:0]     status_now;
	logic [adcs_pkg::FRAME_W-1:0]      frame_new;
	logic [adcs_pkg::FRAME_W-1:0]      frame_old;
	logic [adcs_pkg::FRAME_W-1:0]      chain_sr;
	logic [4:0]                        nbits;
	logic [adcs_pkg::BYTE_W-1:0]       cfg_word;
	adcs_pkg::adcs_rx_t                rx_state_r;
	logic [3:0]                        rx_cnt_r;
	logic [adcs_pkg::BYTE_W-1:0]       cmd_r;
	logic [adcs_pkg::BYTE_W-1:0]       cmd_nxt;
	logic [adcs_pkg::BYTE_W-1:0]       dat_r;
	logic [adcs_pkg::BYTE_W-1:0]       dat_nxt;
	logic                              rd_load_r;
	logic                              wr_load_r;
	logic                              chain_bit_r;
	logic [adcs_pkg::FRAME_W-1:0]      out_sr_r;
	logic [4:0]                        out_left_r;
	logic                              start_bit_r;
	logic                              armed_r;
	logic                              pwrup_r;
	logic [1:0]                        pwrup_cnt_r;

	adcs_sync #(
		.W (4)
	) u_sync (
		.clk      (CLK),
		.nrst     (NRST),
		.async_in ({CLAMP_ACTIVE, SCK, SERIAL_INPUT_PIN, CONVERSION_START_PIN}),
		.sync_out (pins_s)
	);

	assign cnv_s   = pins_s[0];
	assign sdi_s   = pins_s[1];
	assign sck_s   = pins_s[2];
	assign clamp_s = pins_s[3];

	// the core may stall on a full buffer, so no result is dropped
	adcs_buf #(
		.W (adcs_pkg::RESULT_W)
	) u_buf (
		.clk       (CLK),
		.nrst      (NRST),
		.in_valid  (RESULT_VALID),
		.in_ready  (RESULT_READY),
		.in_data   (RESULT_DATA),
		.out_valid (buf_valid),
		.out_ready (conv_r),
		.out_data  (buf_data)
	);

	// edges seen on the sampled pins
	// edges count only once the synchronisers hold real pin levels,
	// so a pin already high at reset release starts no conversion
	assign edges_on = !pwrup_r;
	assign cnv_rise = cnv_s && !cnv_d_r && edges_on;
	assign sck_rise = sck_s && !sck_d_r && edges_on;
	assign sck_fall = !sck_s && sck_d_r && edges_on;
	// three-wire: conversion-start low selects; four-wire: serial input low does
	assign sel      = !(cnv_s && sdi_s);
	assign sel_fall = sel && !sel_d_r;
	assign sel_rise = !sel && sel_d_r;
	assign res_take = buf_valid && conv_r;

	assign status    = {clamp_conv_r, SPAN_COMPRESS, LOW_KICKBACK, EARLY_READOUT, adcs_pkg::STATUS_RSVD};
	// clamp level taken with the result, so the word reports this conversion
	assign status_now = {!clamp_s, status[adcs_pkg::STATUS_W-2:0]};
	assign frame_new = {buf_data, status_now};
	assign frame_old = {last_r, status};
	assign nbits     = status_en_r ? adcs_pkg::FRAME_BITS : adcs_pkg::RESULT_BITS;
	assign cfg_word  = {3'h7, status_en_r, SPAN_COMPRESS, LOW_KICKBACK, EARLY_READOUT, clamp_flag_r};
	assign cmd_nxt   = {cmd_r[adcs_pkg::BYTE_W-2:0], sdi_s};
	assign dat_nxt   = {dat_r[adcs_pkg::BYTE_W-2:0], sdi_s};

	// without status the chained bits must follow the last result bit
	always_comb begin
		chain_sr = {out_sr_r[adcs_pkg::FRAME_W-2:0], chain_bit_r};
		if (!status_en_r)
			chain_sr[adcs_pkg::STATUS_W] = chain_bit_r;
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			cnv_d_r <= 1'b0;
			sck_d_r <= 1'b0;
			sel_d_r <= 1'b1;
		end else begin
			cnv_d_r <= cnv_s;
			sck_d_r <= sck_s;
			sel_d_r <= sel;
		end
	end

	// mode chosen by the serial input level at each conversion-start rise
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST)
			daisy_r <= 1'b0;
		else if (cnv_rise)
			daisy_r <= !sdi_s;
	end

	// conversion runs from the start edge until the core hands its result back
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			conv_r       <= 1'b0;
			CONV_START   <= 1'b0;
			last_r       <= '0;
			clamp_conv_r <= 1'b1;
		end else begin
			CONV_START <= cnv_rise && !conv_r;
			if (cnv_rise)
				conv_r <= 1'b1;
			else if (res_take)
				conv_r <= 1'b0;
			if (res_take) begin
				last_r       <= buf_data;
				clamp_conv_r <= !clamp_s;
			end
		end
	end

	// command receiver; restarts whenever conversion-start is high
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			rx_state_r <= adcs_pkg::RX_HUNT;
			rx_cnt_r   <= 4'h0;
			cmd_r      <= '0;
			dat_r      <= '0;
			rd_load_r  <= 1'b0;
			wr_load_r  <= 1'b0;
		end else begin
			rd_load_r <= 1'b0;
			wr_load_r <= 1'b0;
			if (cnv_s) begin
				rx_state_r <= adcs_pkg::RX_HUNT;
				rx_cnt_r   <= 4'h0;
			end else if (sck_rise) begin
				unique case (rx_state_r)
					adcs_pkg::RX_HUNT: begin
						if (!sdi_s) begin
							cmd_r      <= cmd_nxt;
							rx_cnt_r   <= 4'h1;
							rx_state_r <= adcs_pkg::RX_CMD;
						end
					end
					adcs_pkg::RX_CMD: begin
						cmd_r    <= cmd_nxt;
						rx_cnt_r <= rx_cnt_r + 4'h1;
						if (rx_cnt_r == adcs_pkg::CMD_LAST) begin
							rx_cnt_r   <= 4'h0;
							rx_state_r <= adcs_pkg::RX_DATA;
							rd_load_r  <= (cmd_nxt == adcs_pkg::CMD_READ) && !daisy_r;
						end
					end
					adcs_pkg::RX_DATA: begin
						dat_r    <= dat_nxt;
						rx_cnt_r <= rx_cnt_r + 4'h1;
						if (rx_cnt_r == adcs_pkg::DATA_LAST) begin
							rx_cnt_r   <= 4'h0;
							rx_state_r <= adcs_pkg::RX_HUNT;
							wr_load_r  <= (cmd_r == adcs_pkg::CMD_WRITE);
						end
					end
				endcase
			end
		end
	end

	// writes land whether or not a conversion is running
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			status_en_r   <= adcs_pkg::CFG_RESET[adcs_pkg::CFG_STATUS_EN];
			SPAN_COMPRESS <= adcs_pkg::CFG_RESET[adcs_pkg::CFG_SPAN];
			LOW_KICKBACK  <= adcs_pkg::CFG_RESET[adcs_pkg::CFG_KICKBACK];
			EARLY_READOUT <= adcs_pkg::CFG_RESET[adcs_pkg::CFG_EARLY];
		end else if (wr_load_r) begin
			status_en_r   <= dat_r[adcs_pkg::CFG_STATUS_EN];
			SPAN_COMPRESS <= dat_r[adcs_pkg::CFG_SPAN];
			LOW_KICKBACK  <= dat_r[adcs_pkg::CFG_KICKBACK];
			EARLY_READOUT <= dat_r[adcs_pkg::CFG_EARLY];
		end
	end

	// overvoltage wins over the read that would clear it
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST)
			clamp_flag_r <= adcs_pkg::CFG_RESET[adcs_pkg::CFG_CLAMP];
		else if (clamp_s)
			clamp_flag_r <= 1'b0;
		else if (rd_load_r)
			clamp_flag_r <= 1'b1;
	end

	// daisy-chain input captured on the host's sampling edge
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST)
			chain_bit_r <= 1'b0;
		else if (sck_rise)
			chain_bit_r <= sdi_s;
	end

	// output pin; strobes on the same cycle resolve top to bottom
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			SERIAL_OUTPUT_PIN_O  <= 1'b0;
			SERIAL_OUTPUT_PIN_OE <= 1'b1;
			out_sr_r             <= '0;
			out_left_r           <= 5'h0;
			start_bit_r          <= 1'b0;
			armed_r              <= 1'b0;
			pwrup_r              <= 1'b1;
			pwrup_cnt_r          <= 2'h0;
		end else if (pwrup_r) begin
			// wait for the synchronisers to hold real pin levels
			pwrup_cnt_r <= pwrup_cnt_r + 2'h1;
			if (pwrup_cnt_r == adcs_pkg::PWRUP_WAIT) begin
				pwrup_r              <= 1'b0;
				SERIAL_OUTPUT_PIN_OE <= !(cnv_s && sdi_s);
			end
		end else if (cnv_rise) begin
			start_bit_r          <= 1'b0;
			out_left_r           <= 5'h0;
			SERIAL_OUTPUT_PIN_O  <= 1'b0;
			SERIAL_OUTPUT_PIN_OE <= !sdi_s;
			armed_r              <= EARLY_READOUT && sdi_s;
			if (EARLY_READOUT)
				out_sr_r <= frame_old;
		end else if (res_take) begin
			if (!EARLY_READOUT)
				out_sr_r <= frame_new;
			if (daisy_r) begin
				SERIAL_OUTPUT_PIN_O <= buf_data[adcs_pkg::RESULT_W-1];
			end else if (!EARLY_READOUT && sel) begin
				SERIAL_OUTPUT_PIN_OE <= 1'b1;
				SERIAL_OUTPUT_PIN_O  <= 1'b0;
				start_bit_r          <= 1'b1;
			end else if (!EARLY_READOUT) begin
				armed_r <= 1'b1;
			end
		end else if (rd_load_r) begin
			// MSB repeated so the falling edge ending the command keeps it on the pin
			out_sr_r             <= {cfg_word[adcs_pkg::BYTE_W-1], cfg_word, 15'h0000};
			out_left_r           <= adcs_pkg::READ_BITS;
			SERIAL_OUTPUT_PIN_O  <= cfg_word[adcs_pkg::BYTE_W-1];
			SERIAL_OUTPUT_PIN_OE <= 1'b1;
		end else if (sel_fall && armed_r && !daisy_r && !conv_r) begin
			armed_r              <= 1'b0;
			SERIAL_OUTPUT_PIN_OE <= 1'b1;
			SERIAL_OUTPUT_PIN_O  <= out_sr_r[adcs_pkg::FRAME_W-1];
			out_left_r           <= nbits;
		end else if (sel_rise && !daisy_r) begin
			SERIAL_OUTPUT_PIN_OE <= 1'b0;
			out_left_r           <= 5'h0;
			start_bit_r          <= 1'b0;
		end else if (sck_fall) begin
			if (daisy_r) begin
				out_sr_r            <= chain_sr;
				SERIAL_OUTPUT_PIN_O <= out_sr_r[adcs_pkg::FRAME_W-2];
			end else if (start_bit_r) begin
				start_bit_r         <= 1'b0;
				SERIAL_OUTPUT_PIN_O <= out_sr_r[adcs_pkg::FRAME_W-1];
				out_left_r          <= nbits;
			end else if (out_left_r > 5'h1) begin
				out_sr_r            <= {out_sr_r[adcs_pkg::FRAME_W-2:0], 1'b0};
				SERIAL_OUTPUT_PIN_O <= out_sr_r[adcs_pkg::FRAME_W-2];
				out_left_r          <= out_left_r - 5'h1;
			end else if (out_left_r == 5'h1) begin
				SERIAL_OUTPUT_PIN_OE <= 1'b0;
				out_left_r           <= 5'h0;
			end
		end
	end
endmodule

// ### core/adcs_sync.sv
// two-stage synchroniser for a group of asynchronous pin levels
// assumes each bit is a level that may change at any time
module adcs_sync #(
	parameter int unsigned W = 3
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_r;

	// first stage feeds only the second stage
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_r   <= '0;
			sync_out <= '0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule

// ### tb/adcs_host.sv
// host and converter-core model around the serial port
// assumes one clock per 50 ns; sck runs only inside frames
module adcs_host (
	input  wire logic        CLK,
	input  wire logic        sdo_o,
	input  wire logic        sdo_oe,
	input  wire logic        conv_start,
	input  wire logic        result_ready,
	input  wire logic [17:0] next_word,
	output logic             conversion_start_pin,
	output logic             serial_input_pin,
	output logic             sck,
	output logic             result_valid,
	output logic [17:0]      result_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic sdo_line;
	int   lat = 0;
	// released line shows the inverse so a stale level never passes
	assign sdo_line = sdo_oe ? sdo_o : ~sdo_o;
	initial begin
		conversion_start_pin = 1'b1;
		serial_input_pin = 1'b1;
		sck = 1'b0;
		result_valid = 1'b0;
		result_data = 18'h00000;
	end
	always @(posedge CLK) begin
		if (conv_start)
			lat <= 12;
		else if (lat > 1)
			lat <= lat - 1;
		else if (lat == 1) begin
			lat <= 0;
			result_valid <= 1'b1;
			result_data <= next_word;
		end else if (result_valid && result_ready)
			result_valid <= 1'b0;
	end
	// msb first; sdi moves after sck falls, sdo taken before sck rises
	task automatic xfer(input int n, input logic [23:0] tx, output logic [23:0] rx);
		rx = 24'h000000;
		for (int i = n - 1; i >= 0; i--) begin
			serial_input_pin = tx[i];
			repeat (4) @(negedge CLK);
			rx[i] = sdo_line;
			sck = 1'b1;
			repeat (4) @(negedge CLK);
			sck = 1'b0;
		end
	endtask
endmodule

// ### tb/adcs_port_chk.sv
// pin-level assertions for the converter serial port
// assumes pins are seen 2-4 clocks late through the synchronisers
module adcs_port_chk (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic CONVERSION_START_PIN,
	input wire logic SERIAL_INPUT_PIN,
	input wire logic SCK,
	input wire logic SERIAL_OUTPUT_PIN_O,
	input wire logic SERIAL_OUTPUT_PIN_OE,
	input wire logic CONV_START,
	input wire logic SPAN_COMPRESS,
	input wire logic LOW_KICKBACK,
	input wire logic EARLY_READOUT
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!NRST);
	logic [2:0] cfg;
	assign cfg = {SPAN_COMPRESS, LOW_KICKBACK, EARLY_READOUT};
	chk_start_pulse: assert property (CONV_START |=> !CONV_START)
		else $error("conversion start pulse too long");
	chk_start_cause: assert property (CONV_START |-> $past(CONVERSION_START_PIN, 2)
		&& !$past(CONVERSION_START_PIN, 7)) else $error("conversion start without pin rise");
	chk_start_launch: assert property ($rose(CONVERSION_START_PIN) |-> ##[2:6] CONV_START)
		else $error("pin rise launched no conversion");
	chk_cs_release: assert property ($rose(CONVERSION_START_PIN) && SERIAL_INPUT_PIN
		|-> ##[2:6] !SERIAL_OUTPUT_PIN_OE) else $error("output not released on select rise");
	chk_daisy_low: assert property ($rose(CONVERSION_START_PIN) && !SERIAL_INPUT_PIN
		|-> ##[2:6] (SERIAL_OUTPUT_PIN_OE && !SERIAL_OUTPUT_PIN_O)) else $error("daisy output not low");
	chk_cfg_on_sck: assert property ($changed(cfg) |-> $past(SCK, 1) || $past(SCK, 2)
		|| $past(SCK, 3) || $past(SCK, 4) || $past(SCK, 5)) else $error("config moved without clock");
	chk_cfg_cnv_low: assert property ($changed(cfg) |-> !$past(CONVERSION_START_PIN, 4))
		else $error("config moved with start pin high");
	chk_oe_select: assert property ($rose(SERIAL_OUTPUT_PIN_OE) |->
		!$past(CONVERSION_START_PIN, 3) || !$past(SERIAL_INPUT_PIN, 3)) else $error("drive without select");
endmodule

// ### tb/adcs_port_test.sv
// scenario bench for the converter serial port
// assumes the host model drives the pins at falling clock edges
module adcs_port_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        clamp = 1'b0;
	logic [17:0] word = 18'h00000;
	logic        o, oe, cs, rdy, span, kick, early, conversion_start_pin, serial_input_pin, sck, rv;
	logic [17:0] rd;
	int          n_fail = 0;
	int          cmp_count = 0;
	initial begin
		forever #25 clk = ~clk;
	end
	adcs_port dut_u (.CLK(clk), .NRST(nrst), .CONVERSION_START_PIN(conversion_start_pin), .SERIAL_INPUT_PIN(serial_input_pin), .SCK(sck),
		.SERIAL_OUTPUT_PIN_O(o), .SERIAL_OUTPUT_PIN_OE(oe), .RESULT_DATA(rd), .RESULT_VALID(rv),
		.RESULT_READY(rdy), .CLAMP_ACTIVE(clamp), .CONV_START(cs), .SPAN_COMPRESS(span),
		.LOW_KICKBACK(kick), .EARLY_READOUT(early));
	adcs_host host_u (.CLK(clk), .sdo_o(o), .sdo_oe(oe), .conv_start(cs), .result_ready(rdy),
		.next_word(word), .conversion_start_pin(conversion_start_pin), .serial_input_pin(serial_input_pin), .sck(sck), .result_valid(rv), .result_data(rd));
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk_bit(input string what, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
			n_fail++;
		end
	endtask
	task automatic chk_word(input string what, input logic [23:0] exp, input logic [23:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
			n_fail++;
		end
	endtask
	task automatic conv_done();
		int k;
		for (k = 0; k < 60 && (rv & rdy) !== 1'b1; k++)
			@(negedge clk);
		if (k >= 60) begin
			$display("[FAIL] result handshake expected taken seen none");
			n_fail++;
			tally_and_finish();
		end
	endtask
	// leading ones are hunted away before the command byte
	task automatic reg_acc(input logic [7:0] cmd, input logic [7:0] val, output logic [7:0] got);
		logic [23:0] rx;
		host_u.xfer(24, {8'hFF, cmd, val}, rx);
		got = rx[7:0];
		repeat (4) @(negedge clk);
	endtask
	task automatic t_power(input logic c, input logic exp_oe);
		nrst = 1'b0;
		host_u.conversion_start_pin = c;
		host_u.serial_input_pin = 1'b1;
		repeat (2) @(negedge clk);
		chk_bit("oe in reset", 1'b1, oe);
		nrst = 1'b1;
		repeat (10) @(negedge clk);
		chk_bit("oe after power-up", exp_oe, oe);
		chk_word("cfg outputs", 24'h000000, {21'h0, span, kick, early});
	endtask
	task automatic t_regs();
		logic [7:0] got;
		host_u.conversion_start_pin = 1'b0;
		repeat (8) @(negedge clk);
		reg_acc(adcs_pkg::CMD_READ, 8'h00, got);
		chk_word("cfg reset read", 24'h0000E1, {16'h0, got});
		reg_acc(adcs_pkg::CMD_WRITE, 8'h0E, got);
		chk_word("cfg outputs", 24'h000007, {21'h0, span, kick, early});
		reg_acc(adcs_pkg::CMD_READ, 8'h00, got);
		chk_word("cfg readback", 24'h0000EF, {16'h0, got});
		reg_acc(adcs_pkg::CMD_WRITE, 8'h00, got);
		chk_word("cfg cleared", 24'h000000, {21'h0, span, kick, early});
	endtask
	task automatic t_cs(input logic busy, input logic [17:0] w, input int n, input logic [23:0] exp);
		logic [23:0] rx;
		word = w;
		host_u.serial_input_pin = 1'b1;
		repeat (8) @(negedge clk);
		host_u.conversion_start_pin = 1'b1;
		repeat (8) @(negedge clk);
		if (busy)
			host_u.conversion_start_pin = 1'b0;
		conv_done();
		repeat (8) @(negedge clk);
		host_u.conversion_start_pin = 1'b0;
		repeat (4) @(negedge clk);
		host_u.xfer(n, 24'hFFFFFF, rx);
		chk_word("result frame", exp, rx);
		repeat (8) @(negedge clk);
		if (!busy)
			chk_bit("released", 1'b0, oe);
	endtask
	task automatic t_status();
		logic [7:0] got;
		reg_acc(adcs_pkg::CMD_WRITE, 8'h18, got);
		clamp = 1'b1;
		t_cs(1'b0, 18'h0F0F1, 24, {18'h0F0F1, 6'h10});
		clamp = 1'b0;
		repeat (8) @(negedge clk);
		reg_acc(adcs_pkg::CMD_READ, 8'h00, got);
		chk_word("sticky clamp", 24'h0000F8, {16'h0, got});
		reg_acc(adcs_pkg::CMD_READ, 8'h00, got);
		chk_word("clamp cleared", 24'h0000F9, {16'h0, got});
		reg_acc(adcs_pkg::CMD_WRITE, 8'h00, got);
	endtask
	// early readout hands out the previous result, no start bit
	task automatic t_early();
		logic [7:0] got;
		reg_acc(adcs_pkg::CMD_WRITE, 8'h02, got);
		t_cs(1'b0, 18'h3F00F, 18, 24'h015A3C);
	endtask
	// no register reads here: only writes are legal in the chain
	task automatic t_daisy();
		logic [23:0] rx;
		word = 18'h2C3A7;
		host_u.serial_input_pin = 1'b0;
		repeat (8) @(negedge clk);
		host_u.conversion_start_pin = 1'b1;
		repeat (8) @(negedge clk);
		chk_bit("daisy level", 1'b0, o);
		chk_bit("daisy drive", 1'b1, oe);
		conv_done();
		repeat (8) @(negedge clk);
		host_u.xfer(20, 24'h055555, rx);
		chk_word("daisy chain", {4'h0, 18'h2C3A7, 2'b01}, rx);
	endtask
	initial begin
		t_power(1'b1, 1'b0);
		t_regs();
		t_cs(1'b0, 18'h2A5C3, 18, 24'h02A5C3);
		t_cs(1'b1, 18'h15A3C, 19, 24'h015A3C);
		t_early();
		t_status();
		t_daisy();
		t_power(1'b0, 1'b1);
		chk_bit("power-up level", 1'b0, o);
		tally_and_finish();
	end
endmodule
bind adcs_port adcs_port_chk chk_u (.CLK(CLK), .NRST(NRST), .CONVERSION_START_PIN(CONVERSION_START_PIN),
	.SERIAL_INPUT_PIN(SERIAL_INPUT_PIN), .SCK(SCK), .SERIAL_OUTPUT_PIN_O(SERIAL_OUTPUT_PIN_O),
	.SERIAL_OUTPUT_PIN_OE(SERIAL_OUTPUT_PIN_OE), .CONV_START(CONV_START), .SPAN_COMPRESS(SPAN_COMPRESS),
	.LOW_KICKBACK(LOW_KICKBACK), .EARLY_READOUT(EARLY_READOUT));
